// ### pkg/math_chain_map.svh
`ifndef MATH_CHAIN_MAP_SVH
`define MATH_CHAIN_MAP_SVH
// ****************************************
// fixed point: 1.0 (100 %) is 2**14
// ****************************************
`define PCT_ONE      16'h4000
`define PCT_HALF     16'h2000
`define PCT_FRAC     14
// ****************************************
// register map, byte addresses
// ****************************************
`define REG_CTRL     10'h200
`define REG_STAT     10'h204
`define FLD_IN_MIN   2'h0
`define FLD_IN_MAX   2'h1
`define FLD_IN_WGT   2'h2
`define FLD_IN_SRC   2'h3
`define BREG_OPS     4'h0
`define BREG_OMIN    4'h1
`define BREG_OMAX    4'h2
`define BREG_OUT     4'h3
`define BREG_FRES1   4'h4
`define BREG_FRES2   4'h5
`define BREG_FRES3   4'h6
// ****************************************
// input source codes, reset values
// ****************************************
`define SRC_NONE     2'h0
`define SRC_EXT      2'h1
`define SRC_OWN      2'h2
`define RST_IN_MAX   16'h0fff
`define RST_OUT_MAX  16'h0fff
`define RST_OPS      12'h999
`endif

// ### pkg/math_chain_pkg.sv
`default_nettype none
package math_chain_pkg;
   typedef logic signed [15:0] pct_t;
   typedef enum logic [3:0] {
      OP_EQ = 4'h0, OP_NE = 4'h1, OP_GT = 4'h2, OP_GE = 4'h3,
      OP_LT = 4'h4, OP_LE = 4'h5, OP_OR = 4'h6, OP_AND = 4'h7,
      OP_XOR = 4'h8, OP_ADD = 4'h9, OP_SUB = 4'ha, OP_MUL = 4'hb,
      OP_DIV = 4'hc, OP_MIN = 4'hd, OP_MAX = 4'he
   } op_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001, S_LOAD = 4'b0010,
      S_FUNC = 4'b0100, S_OUT = 4'b1000
   } seq_state_t;
endpackage
`default_nettype wire

// ### pkg/math_fn_if.sv
`timescale 1ns/1ps
`default_nettype none
// operands and result of one two-operand function
interface math_fn_if (
   input wire logic clk,
   input wire logic rst
);
   import math_chain_pkg::*;
   op_t  op;
   pct_t a;
   pct_t b;
   pct_t res;
   modport unit (input clk, rst, op, a, b, output res);
   modport user (output op, a, b, input res);
endinterface
`default_nettype wire

// ### rtl/math_normalize.sv
`timescale 1ns/1ps
`default_nettype none
`include "math_chain_map.svh"
module math_normalize (
   // clock for checks only
   input  wire logic                  clk,
   input  wire logic                  rst,
   // raw input and its limits
   input  wire math_chain_pkg::pct_t  raw,
   input  wire math_chain_pkg::pct_t  lo,
   input  wire math_chain_pkg::pct_t  hi,
   input  wire math_chain_pkg::pct_t  wgt,
   input  wire logic                  err,
   // weighted percentage
   output var  math_chain_pkg::pct_t  out
);
   import math_chain_pkg::*;
   localparam pct_t ONE = `PCT_ONE;
   logic signed [16:0] span;
   logic signed [16:0] num;
   logic signed [31:0] frac;
   logic signed [31:0] prod;
   pct_t               pct;

   // ****************************************
   // span position, then weight
   // ****************************************
   assign span = 17'(hi) - 17'(lo);
   assign num  = 17'(raw) - 17'(lo);
   assign frac = (span <= 0) ? '0 : (32'(num) <<< `PCT_FRAC) / 32'(span);
   assign pct  = (err || span <= 0 || num <= 0) ? '0 :
                 (num >= span) ? ONE : pct_t'(frac[15:0]);
   assign prod = 32'(pct) * 32'(wgt);
   assign out  = pct_t'(prod[29:14]);

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   err_zero_a: assert property (err |-> out == '0)
      else $error("error input not zeroed");
   below_min_a: assert property (!err && raw <= lo |-> out == '0)
      else $error("input at minimum not zero");
   full_wgt_a: assert property (!err && hi > lo && raw >= hi
      && wgt == ONE |-> out == ONE)
      else $error("full input at unit weight not full");
endmodule // math_normalize
`default_nettype wire

// ### rtl/math_func_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "math_chain_map.svh"
module math_func_unit (
   // operands, operator and result
   math_fn_if.unit fu
);
   import math_chain_pkg::*;
   localparam pct_t ONE  = `PCT_ONE;
   localparam pct_t HALF = `PCT_HALF;
   logic signed [31:0] wide;
   logic               ta;
   logic               tb;
   logic               truth;
   pct_t               lo;
   pct_t               arith;

   // ****************************************
   // truth values and clamp floor
   // ****************************************
   assign ta = fu.a >= HALF;
   assign tb = fu.b >= HALF;
   assign lo = (fu.a < 0 || fu.b < 0) ? -ONE : '0;
   assign arith = (wide > 32'(ONE)) ? ONE :
                  (wide < 32'(lo)) ? lo : pct_t'(wide[15:0]);
   assign fu.res = (fu.op <= OP_XOR) ? (truth ? ONE : '0) : arith;

   // compare and logic operators
   always_comb
   begin
      case (fu.op)
         OP_EQ:   truth = fu.a == fu.b;
         OP_NE:   truth = fu.a != fu.b;
         OP_GT:   truth = fu.a > fu.b;
         OP_GE:   truth = fu.a >= fu.b;
         OP_LT:   truth = fu.a < fu.b;
         OP_LE:   truth = fu.a <= fu.b;
         OP_OR:   truth = ta | tb;
         OP_AND:  truth = ta & tb;
         OP_XOR:  truth = ta ^ tb;
         default: truth = 1'b0;
      endcase
   end

   // arithmetic operators, before saturation
   always_comb
   begin
      case (fu.op)
         OP_ADD:  wide = 32'(fu.a) + 32'(fu.b);
         OP_SUB:  wide = 32'(fu.a) - 32'(fu.b);
         OP_MUL:  wide = (32'(fu.a) * 32'(fu.b)) >>> `PCT_FRAC;
         OP_DIV:  wide = (fu.b == '0) ? '0 :
                         (32'(fu.a) <<< `PCT_FRAC) / 32'(fu.b);
         OP_MIN:  wide = (fu.a < fu.b) ? 32'(fu.a) : 32'(fu.b);
         OP_MAX:  wide = (fu.a > fu.b) ? 32'(fu.a) : 32'(fu.b);
         default: wide = '0;
      endcase
   end

   default clocking @(posedge fu.clk); endclocking
   default disable iff (fu.rst);
   bool_result_a: assert property (fu.op <= OP_XOR
      |-> fu.res == ONE || fu.res == '0)
      else $error("logic result not 0 or 1");
   equal_true_a: assert property (fu.op == OP_EQ && fu.a == fu.b
      |-> fu.res == ONE)
      else $error("equal operands not true");
   or_half_a: assert property (fu.op == OP_OR && fu.a < HALF
      && fu.b < HALF |-> fu.res == '0)
      else $error("or below half not false");
   div_zero_a: assert property (fu.op == OP_DIV && fu.b == '0
      |-> fu.res == '0)
      else $error("divide by zero not zero");
   sat_top_a: assert property (fu.op >= OP_ADD |-> fu.res <= ONE)
      else $error("arithmetic above full scale");
   sub_floor_a: assert property (fu.op == OP_SUB && fu.a >= 0
      && fu.b >= 0 |-> fu.res >= 0)
      else $error("positive subtraction went negative");
endmodule // math_func_unit
`default_nettype wire

// ### rtl/four_input_math_chain.sv
`timescale 1ns/1ps
`default_nettype none
`include "math_chain_map.svh"
// Operation
// - four math blocks, four inputs each
// - inputs scaled to percent of span
// - per-input weight, default 1.0, -1..1; the weight register takes any 16-bit value and is not limited to that range
// - codes 0-5 compare first to second
// - codes 6-8 give OR, AND, XOR
// - codes 9-14 give arithmetic, min, max
// - functions chain inputs one to four
// - own-block input takes chosen function result
// - unused input skips function, earlier result out
// - logic operand true at half or above
// - compare and logic results are 0 or 1
// - input in error enters as zero
// - arithmetic saturates at full scale
// - divide by zero gives zero
// - negative difference clamped unless negatives used
// - result mapped onto output limits
module four_input_math_chain #(
   parameter int NB = 4
) (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // register port
   input  wire logic [9:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [31:0]            reg_rdata,
   // inputs from other function blocks
   input  wire logic [NB*4*16-1:0]     in_value,
   input  wire logic [NB*4-1:0]        in_error,
   // block outputs in physical units
   output logic      [NB*16-1:0]       out_value,
   output logic                        update_done
);
   import math_chain_pkg::*;
   localparam pct_t ONE = `PCT_ONE;

   // ****************************************
   // configuration and state storage
   // ****************************************
   pct_t        in_min [NB][4];
   pct_t        in_max [NB][4];
   pct_t        in_wgt [NB][4];
   logic [3:0]  in_src [NB][4];
   logic [11:0] ops    [NB];
   pct_t        out_min[NB];
   pct_t        out_max[NB];
   pct_t        fin_pct[NB];
   pct_t        fres   [NB][3];
   pct_t        norm   [4];
   seq_state_t  state;
   logic [1:0]  blk;
   logic [1:0]  idx;
   logic [1:0]  fn;
   logic        run;
   logic        live;
   pct_t        acc;

   // ****************************************
   // address decode
   // ****************************************
   logic        sel_ctrl;
   logic        sel_stat;
   logic        sel_in;
   logic        sel_blk;
   logic [1:0]  a_blk;
   logic [1:0]  a_inp;
   logic [1:0]  a_fld;
   logic [3:0]  a_bidx;
   logic [31:0] rd_mux;

   // field selects from the byte address
   assign sel_ctrl = reg_addr == `REG_CTRL;
   assign sel_stat = reg_addr == `REG_STAT;
   assign sel_in   = !reg_addr[9] && !reg_addr[6] && reg_addr[1:0] == 2'h0;
   assign sel_blk  = !reg_addr[9] && reg_addr[6] && reg_addr[1:0] == 2'h0;
   assign a_blk    = reg_addr[8:7];
   assign a_inp    = reg_addr[5:4];
   assign a_fld    = reg_addr[3:2];
   assign a_bidx   = reg_addr[5:2];

   // read selection, unmapped reads give zero
   always_comb
   begin
      rd_mux = '0;
      if (sel_ctrl)
         rd_mux = {31'h0, run};
      else if (sel_stat)
         rd_mux = {26'h0, blk, state};
      else if (sel_in && a_fld == `FLD_IN_MIN)
         rd_mux = {16'h0, in_min[a_blk][a_inp]};
      else if (sel_in && a_fld == `FLD_IN_MAX)
         rd_mux = {16'h0, in_max[a_blk][a_inp]};
      else if (sel_in && a_fld == `FLD_IN_WGT)
         rd_mux = {16'h0, in_wgt[a_blk][a_inp]};
      else if (sel_in && a_fld == `FLD_IN_SRC)
         rd_mux = {28'h0, in_src[a_blk][a_inp]};
      else if (sel_blk && a_bidx == `BREG_OPS)
         rd_mux = {20'h0, ops[a_blk]};
      else if (sel_blk && a_bidx == `BREG_OMIN)
         rd_mux = {16'h0, out_min[a_blk]};
      else if (sel_blk && a_bidx == `BREG_OMAX)
         rd_mux = {16'h0, out_max[a_blk]};
      else if (sel_blk && a_bidx == `BREG_OUT)
         rd_mux = {16'h0, fin_pct[a_blk]};
      else if (sel_blk && a_bidx == `BREG_FRES1)
         rd_mux = {16'h0, fres[a_blk][0]};
      else if (sel_blk && a_bidx == `BREG_FRES2)
         rd_mux = {16'h0, fres[a_blk][1]};
      else if (sel_blk && a_bidx == `BREG_FRES3)
         rd_mux = {16'h0, fres[a_blk][2]};
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         reg_rdata <= '0;
      else
         reg_rdata <= reg_rd ? rd_mux : '0;
   end

   // ****************************************
   // register writes
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         run <= 1'b0;
         for (int b = 0; b < NB; b++)
         begin
            ops[b]     <= `RST_OPS;
            out_min[b] <= '0;
            out_max[b] <= `RST_OUT_MAX;
            for (int i = 0; i < 4; i++)
            begin
               in_min[b][i] <= '0;
               in_max[b][i] <= `RST_IN_MAX;
               in_wgt[b][i] <= `PCT_ONE;
               in_src[b][i] <= {2'h0, `SRC_NONE};
            end
         end
      end
      else if (reg_wr)
      begin
         if (sel_ctrl)
            run <= reg_wdata[0];
         else if (sel_in && a_fld == `FLD_IN_MIN)
            in_min[a_blk][a_inp] <= reg_wdata[15:0];
         else if (sel_in && a_fld == `FLD_IN_MAX)
            in_max[a_blk][a_inp] <= reg_wdata[15:0];
         else if (sel_in && a_fld == `FLD_IN_WGT)
            in_wgt[a_blk][a_inp] <= reg_wdata[15:0];
         else if (sel_in && a_fld == `FLD_IN_SRC)
            in_src[a_blk][a_inp] <= reg_wdata[3:0];
         else if (sel_blk && a_bidx == `BREG_OPS)
            ops[a_blk] <= reg_wdata[11:0];
         else if (sel_blk && a_bidx == `BREG_OMIN)
            out_min[a_blk] <= reg_wdata[15:0];
         else if (sel_blk && a_bidx == `BREG_OMAX)
            out_max[a_blk] <= reg_wdata[15:0];
      end
   end

   // ****************************************
   // operand selection
   // ****************************************
   // input value: none, normalised external, or own result
   function automatic pct_t pick(input logic [3:0] src, input pct_t nrm,
                                 input pct_t f1, input pct_t f2,
                                 input pct_t f3, input pct_t fin);
      pct_t v;
      v = '0;
      if (src[1:0] == `SRC_EXT)
         v = nrm;
      else if (src[1:0] == `SRC_OWN)
      begin
         case (src[3:2])
            2'h1:    v = f1;
            2'h2:    v = f2;
            2'h3:    v = f3;
            default: v = fin;
         endcase
      end
      return v;
   endfunction

   logic [3:0]         nidx;
   logic [1:0]         fnb;
   logic [3:0]         src_b;
   logic               fn_used;
   pct_t               nrm_out;
   pct_t               in_first;
   pct_t               acc_c;
   pct_t               omap;
   logic signed [16:0] ospan;
   logic signed [33:0] oprod;

   // normaliser feeds one input of the current block per cycle
   assign nidx = {blk, idx};

   math_normalize u_norm (
      .clk (clk_sys),
      .rst (rst),
      .raw (in_value[{nidx, 4'h0} +: 16]),
      .lo  (in_min[blk][idx]),
      .hi  (in_max[blk][idx]),
      .wgt (in_wgt[blk][idx]),
      .err (in_error[nidx]),
      .out (nrm_out)
   );

   math_fn_if fu (.clk(clk_sys), .rst(rst));

   math_func_unit u_func (
      .fu (fu.unit)
   );

   // function k takes the chain value and input k+1
   assign fnb      = 2'(fn + 2'h1);
   assign src_b    = in_src[blk][fnb];
   assign in_first = pick(in_src[blk][0], norm[0], fres[blk][0],
                          fres[blk][1], fres[blk][2], fin_pct[blk]);
   assign fu.op    = op_t'(ops[blk][{fn, 2'b00} +: 4]);
   assign fu.a     = acc;
   assign fu.b     = pick(src_b, norm[fnb], fres[blk][0],
                          fres[blk][1], fres[blk][2], fin_pct[blk]);
   assign fn_used  = live && src_b[1:0] != `SRC_NONE &&
                     (fn != 2'h0 || in_src[blk][0][1:0] != `SRC_NONE);

   // percent result onto the output limits
   assign acc_c = (acc < 0) ? '0 : (acc > ONE) ? ONE : acc;
   assign ospan = 17'(out_max[blk]) - 17'(out_min[blk]);
   assign oprod = 34'(acc_c) * 34'(ospan);
   assign omap  = out_min[blk] + pct_t'(oprod[29:14]);

   // ****************************************
   // update sequencer
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state       <= S_IDLE;
         blk         <= '0;
         idx         <= '0;
         fn          <= '0;
         live        <= 1'b0;
         acc         <= '0;
         update_done <= 1'b0;
         out_value   <= '0;
         for (int i = 0; i < 4; i++)
            norm[i] <= '0;
         for (int b = 0; b < NB; b++)
         begin
            fin_pct[b] <= '0;
            for (int f = 0; f < 3; f++)
               fres[b][f] <= '0;
         end
      end
      else
      begin
         update_done <= 1'b0;
         case (state)
            S_IDLE:
            begin
               blk <= '0;
               idx <= '0;
               if (run)
                  state <= S_LOAD;
            end
            S_LOAD:
            begin
               norm[idx] <= nrm_out;
               idx       <= 2'(idx + 2'h1);
               if (idx == 2'h3)
               begin
                  state <= S_FUNC;
                  fn    <= '0;
                  live  <= 1'b1;
                  acc   <= in_first;
               end
            end
            S_FUNC:
            begin
               if (fn_used)
               begin
                  fres[blk][fn] <= fu.res;
                  acc           <= fu.res;
               end
               else
                  live <= 1'b0;
               // wrap to zero so the operator select stays in range
               fn <= (fn == 2'h2) ? 2'h0 : 2'(fn + 2'h1);
               if (fn == 2'h2)
                  state <= S_OUT;
            end
            S_OUT:
            begin
               fin_pct[blk]            <= acc;
               out_value[{blk, 4'h0} +: 16] <= omap;
               idx                     <= '0;
               blk                     <= 2'(blk + 2'h1);
               if (32'(blk) == NB - 1)
               begin
                  state       <= S_IDLE;
                  update_done <= 1'b1;
               end
               else
                  state <= S_LOAD;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence load_end_s;
      state == S_LOAD && idx == 2'h3;
   endsequence
   sequence chain_end_s;
      state == S_FUNC && fn == 2'h2;
   endsequence
   load_then_func_a: assert property (load_end_s
      |=> state == S_FUNC && fn == 2'h0)
      else $error("functions did not start after loading");
   chain_order_a: assert property (load_end_s ##1 (state == S_FUNC)[*3]
      |=> state == S_OUT)
      else $error("three functions not run in order");
   skip_hold_a: assert property (state == S_FUNC && !fn_used
      |=> acc == $past(acc) && !live)
      else $error("skipped function changed result");
   out_floor_a: assert property (state == S_OUT && acc <= 0
      |-> omap == out_min[blk])
      else $error("zero result not at output minimum");
   done_pulse_a: assert property (chain_end_s ##1 state == S_OUT
      && 32'(blk) == NB - 1 |=> update_done ##1 !update_done)
      else $error("update done not a single pulse");
   read_zero_a: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data outside read cycle");
endmodule // four_input_math_chain
`default_nettype wire

// ### dv/input_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// function blocks feeding the math chain
// ****************************************
module input_source_model #(
   parameter int NB = 4
) (
   // clock
   input  wire logic              clk_sys,
   // block 0 inputs chosen by the bench
   input  wire logic [63:0]       vals,
   input  wire logic [3:0]        errs,
   // raw inputs of all blocks
   output var  logic [NB*64-1:0]  in_value,
   output var  logic [NB*4-1:0]   in_error
);
   logic [15:0] churn = 16'h0;

   // idle blocks see values that move every cycle
   always @(posedge clk_sys)
   begin
      churn <= churn + 16'h1357;
      in_value <= {{(NB*4-4){churn}}, vals};
      in_error <= {{(NB*4-4){churn[0]}}, errs};
   end
endmodule // input_source_model
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import math_chain_pkg::*;
   localparam int NB = 4;
   logic              clk_sys = 1'b0;
   logic              rst = 1'b1;
   logic [9:0]        reg_addr = 10'h0;
   logic [31:0]       reg_wdata = 32'h0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [31:0]       reg_rdata;
   logic [NB*64-1:0]  in_value;
   logic [NB*4-1:0]   in_error;
   logic [NB*16-1:0]  out_value;
   logic              update_done;
   logic [63:0]       vals = 64'h0;
   logic [3:0]        errs = 4'h0;
   logic              rd_seen = 1'b0;
   logic [31:0]       exp_q[$];
   logic [15:0]       out_q[$];
   int                n_fail = 0;
   int                n_checks = 0;
   int                cyc = 0;
   int                i;
   logic [31:0]       seed_v;

   // 200 MHz clock
   always #2.5 clk_sys = ~clk_sys;

   four_input_math_chain #(.NB(NB)) dut_u (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .reg_addr    (reg_addr),
      .reg_wdata   (reg_wdata),
      .reg_wr      (reg_wr),
      .reg_rd      (reg_rd),
      .reg_rdata   (reg_rdata),
      .in_value    (in_value),
      .in_error    (in_error),
      .out_value   (out_value),
      .update_done (update_done)
   );

   input_source_model #(.NB(NB)) src_u (
      .clk_sys  (clk_sys),
      .vals     (vals),
      .errs     (errs),
      .in_value (in_value),
      .in_error (in_error)
   );

   // ****************************************
   // comparison, verdict and bus tasks
   // ****************************************
   task check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  want);
      end
   endtask

   task test_done();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // a read notes its expected data for the monitor
   task rd(input logic [9:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask

   task wait_done();
      int k;
      k = 0;
      @(negedge clk_sys);
      while (update_done !== 1'b1 && k < 100)
      begin
         @(negedge clk_sys);
         k++;
      end
      if (k == 100)
         n_fail++;
      @(negedge clk_sys);
   endtask

   // monitor: read data and block output against oldest notes
   always @(posedge clk_sys)
   begin
      rd_seen <= reg_rd;
      cyc <= cyc + 1;
      if (rd_seen && exp_q.size() > 0)
         check(reg_rdata, exp_q.pop_front());
      if (update_done === 1'b1 && out_q.size() > 0)
         check({16'h0, out_value[15:0]}, {16'h0, out_q.pop_front()});
      if (update_done === 1'b1)
         check({16'h0, out_value[63:48]}, 32'h0);
      if (cyc == 20000)
      begin
         n_fail++;
         test_done();
      end
   end

   // ****************************************
   // reference model of one function
   // ****************************************
   function automatic pct_t f_op(input logic [3:0] op, input pct_t a,
                                 input pct_t b);
      int   r;
      logic ta;
      logic tb;
      ta = (a >= 16'sh2000);
      tb = (b >= 16'sh2000);
      case (op)
         4'h0: r = (a == b);
         4'h1: r = (a != b);
         4'h2: r = (a > b);
         4'h3: r = (a >= b);
         4'h4: r = (a < b);
         4'h5: r = (a <= b);
         4'h6: r = ta | tb;
         4'h7: r = ta & tb;
         4'h8: r = ta ^ tb;
         4'h9: r = int'(a) + int'(b);
         4'ha: r = int'(a) - int'(b);
         4'hb: r = (int'(a) * int'(b)) >>> 14;
         4'hc: r = (b == 0) ? 0 : int'(a) * 16384 / int'(b);
         4'hd: r = (a < b) ? a : b;
         default: r = (a > b) ? a : b;
      endcase
      if (op <= 4'h8)
         r = r * 16384;
      if (r < 0)
         r = 0;
      if (r > 16384)
         r = 16384;
      return pct_t'(r);
   endfunction

   // one configuration of block 0, two update passes, then readback
   task run_case(input logic [11:0] ops, input logic [3:0] s3,
                 input logic [3:0] s4, input logic [3:0] er);
      pct_t v[4];
      pct_t f1;
      pct_t f2;
      pct_t f3;
      pct_t fin;
      int   k;
      wr(10'h200, 32'h0);
      repeat (40) @(posedge clk_sys);
      for (k = 0; k < 4; k++)
      begin
         case ($urandom_range(3, 0))
            0: v[k] = 16'h0;
            1: v[k] = 16'h2000;
            default: v[k] = pct_t'($urandom_range(16384, 0));
         endcase
      end
      vals <= {v[3], v[2], v[1], v[0]};
      errs <= er;
      wr(10'h00c, 32'h1);
      wr(10'h01c, 32'h1);
      wr(10'h02c, {28'h0, s3});
      wr(10'h03c, {28'h0, s4});
      wr(10'h040, {20'h0, ops});
      for (k = 0; k < 4; k++)
         if (er[k])
            v[k] = 16'h0;
      f1 = f_op(ops[3:0], v[0], v[1]);
      f2 = f_op(ops[7:4], f1, (s3 == 4'h6) ? f1 : v[2]);
      f3 = f_op(ops[11:8], f2, v[3]);
      fin = (s4 == 4'h0) ? f2 : f3;
      out_q.push_back(16'h1000 + 16'((int'(fin) * 8192) >>> 14));
      wr(10'h200, 32'h1);
      wait_done();
      wait_done();
      wr(10'h200, 32'h0);
      repeat (40) @(posedge clk_sys);
      rd(10'h050, {16'h0, f1});
      rd(10'h054, {16'h0, f2});
      if (s4 != 4'h0)
         rd(10'h058, {16'h0, f3});
      rd(10'h04c, {16'h0, fin});
      $display("test done: ops %h", ops);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      seed_v = $urandom(32'h82d34fc6);
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      check({16'h0, out_value[15:0]}, 32'h0);
      rd(10'h200, 32'h0);
      rd(10'h040, 32'h999);
      rd(10'h1c0, 32'h999);
      rd(10'h004, 32'hfff);
      rd(10'h008, 32'h4000);
      rd(10'h00c, 32'h0);
      rd(10'h044, 32'h0);
      rd(10'h048, 32'hfff);
      rd(10'h204, 32'h1);
      wr(10'h04c, 32'h1234);
      rd(10'h04c, 32'h0);
      rd(10'h3fc, 32'h0);
      rd(10'h042, 32'h0);
      $display("test done: reset values");
      for (i = 0; i < 4; i++)
         wr(10'(i * 16 + 4), 32'h4000);
      wr(10'h044, 32'h1000);
      wr(10'h048, 32'h3000);
      for (i = 0; i < 30; i++)
         run_case({4'($urandom_range(14, 0)), 4'($urandom_range(14, 0)),
                   4'(i % 15)}, 4'h1, 4'h1, 4'h0);
      run_case(12'h999, 4'h1, 4'h1, 4'h2);
      run_case(12'h9aa, 4'h6, 4'h1, 4'h0);
      run_case(12'h09a, 4'h1, 4'h0, 4'h0);
      test_done();
   end
endmodule // testbench
`default_nettype wire
